// file: dv/prl_link_partner.sv
// Purpose: far side model raising link and internal error events
// Assumes: events launched just after a rising edge
// Notes:   each event is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module prl_link_partner
  import prl_pkg::*;
(
  input  wire logic       i_clk,
  output var prl_err_evt_t o_err_evt,
  output var logic        o_int_err
);
  // idle with no event raised
  initial begin
    o_err_evt = '0;
    o_int_err = 1'b0;
  end
  // pulse the chosen events for exactly one clock
  task automatic send(input prl_err_evt_t e, input logic ie);
    @(posedge i_clk);
    #1;
    o_err_evt = e;
    o_int_err = ie;
    @(posedge i_clk);
    #1;
    o_err_evt = '0;
    o_int_err = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_prl_regs.sv
// Purpose: self-checking bench for the port register bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   a chipset port instance shares the config bus
`include "prl_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_prl_regs
  import prl_pkg::*;
;
  logic         clk;
  logic         reset;
  prl_cfg_req_t cfg;
  prl_err_evt_t evt;
  logic         ie;
  logic [31:0]  rdata;
  logic [31:0]  cs_rdata;
  logic         rvalid;
  logic         ext_tag;
  logic         mps;
  logic         cs_mps;
  logic         rlx;
  prl_err_rpt_t rpt;
  logic         irpt;
  prl_link_cap_t lcap;
  int           bad_count;
  int           total_checks;

  prl_link_partner partner (.i_clk(clk), .o_err_evt(evt), .o_int_err(ie));
  prl_regs dut (.i_clk(clk), .i_reset(reset), .i_cfg(cfg), .i_err_evt(evt),
    .i_int_err(ie), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
    .o_ext_tag_en(ext_tag), .o_mps_256(mps), .o_relaxed_ord(rlx),
    .o_err_rpt(rpt), .o_int_err_rpt(irpt), .o_link_cap(lcap));
  prl_regs #(.IS_CHIPSET_PORT(1'b1)) dut_cs (.i_clk(clk), .i_reset(reset),
    .i_cfg(cfg), .i_err_evt(evt), .i_int_err(ie), .o_cfg_rdata(cs_rdata),
    .o_cfg_rvalid(), .o_ext_tag_en(), .o_mps_256(cs_mps),
    .o_relaxed_ord(), .o_err_rpt(), .o_int_err_rpt(), .o_link_cap());

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one write access, strobe held for one edge
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg.wr = 1'b1;
    cfg.addr = a;
    cfg.be = be;
    cfg.wdata = d;
    @(posedge clk);
    #1;
    cfg.wr = 1'b0;
  endtask
  // one read access, answer stands in the following cycle
  task automatic cfg_rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    cfg.rd = 1'b1;
    cfg.addr = a;
    @(posedge clk);
    #1;
    cfg.rd = 1'b0;
    check("rvalid", {31'h0, rvalid}, 32'h1);
  endtask

  task automatic t_reset;
    cfg_rd(`PRL_OFS_LINK_CAP);
    check("link cap", rdata, 32'h00393C42);
    check("cs link cap", cs_rdata, 32'h00393C41);
    check("lcap port", lcap, {8'h00, 3'h2, 3'h3, 2'h3, 6'h04, 4'h2});
    cfg_rd(`PRL_OFS_DEVCTL);
    check("devctl rst", rdata, 32'h0);
    cfg_rd(8'h10);
    check("unmapped", rdata, 32'h0);
  endtask
  task automatic t_devctl;
    cfg_wr(`PRL_OFS_DEVCTL, 4'h3, 32'h0000FFFF);
    cfg_rd(`PRL_OFS_DEVCTL);
    check("devctl rw", rdata, 32'h000001EF);
    check("ext tag", ext_tag, 32'h1);
    check("relaxed", rlx, 32'h0);
    for (int c = 0; c < 8; c++) begin
      cfg_wr(`PRL_OFS_DEVCTL, 4'h1, {24'h0, 3'(c), 5'h0});
      @(posedge clk);
      #1;
      check("mps", mps, {31'h0, c == 1});
      check("cs mps", cs_mps, 32'h0);
    end
    cfg_wr(`PRL_OFS_DEVCTL, 4'h3, 32'h0);
    @(posedge clk);
    #1;
    check("ext tag off", ext_tag, 32'h0);
  endtask
  task automatic t_errors;
    partner.send(prl_err_evt_t'(5'b10111), 1'b1);
    check("rpt off", rpt, 32'h0);
    check("int rpt", irpt, 32'h1);
    cfg_rd(`PRL_OFS_DEVCTL);
    check("flags", rdata, 32'h000F0000);
    cfg_wr(`PRL_OFS_DEVCTL, 4'h4, 32'h00040000);
    cfg_rd(`PRL_OFS_DEVCTL);
    check("w1c", rdata, 32'h000B0000);
    cfg_wr(`PRL_OFS_DEVCTL, 4'h4, 32'h000F0000);
    partner.send(prl_err_evt_t'(5'b01000), 1'b0);
    cfg_rd(`PRL_OFS_DEVCTL);
    check("fwd cpl", rdata, 32'h0);
    cfg_wr(`PRL_OFS_DEVCTL, 4'h1, 32'h0000000F);
    for (int i = 0; i < 4; i++) begin
      partner.send(prl_err_evt_t'(i == 3 ? 5'h10 : 5'(1 << i)), 1'b0);
      check("rpt on", rpt, 32'(1 << i));
      @(posedge clk);
      #1;
      check("rpt pulse", rpt, 32'h0);
    end
  endtask
  task automatic t_once;
    cfg_wr(`PRL_OFS_LINK_CAP, 4'hF, 32'h0501D481);
    cfg_wr(`PRL_OFS_LINK_CAP, 4'hF, 32'hFFFFFFFF);
    cfg_rd(`PRL_OFS_LINK_CAP);
    check("once", rdata, 32'h0539D481);
    check("cs once", cs_rdata, 32'h0539D481);
    check("lcap out", lcap, {8'h05, 3'h3, 3'h5, 2'h1, 6'h08, 4'h1});
    cfg_wr(`PRL_OFS_LINK_CTL, 4'h3, 32'h00000E00);
    cfg_rd(`PRL_OFS_LINK_CTL);
    check("cs link ctl", cs_rdata, 32'h0);
  endtask

  // watchdog against a hang
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  // main sequence
  initial begin
    bad_count = 0;
    total_checks = 0;
    cfg = '0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_devctl();
    t_errors();
    t_once();
    stop_test();
  end
endmodule
`default_nettype wire

// file: hdl/prl_params.svh
// Purpose: offsets, field positions, reset values of the port registers
// Assumes: config space byte offsets, one aligned dword per access
// Notes:   definitions only
`ifndef PRL_PARAMS_SVH
`define PRL_PARAMS_SVH
// byte offsets of the dwords in configuration space
`define PRL_OFS_DEVCTL      8'h98
`define PRL_OFS_LINK_CAP    8'h9C
`define PRL_OFS_LINK_CTL    8'hA0
// device control fields
`define PRL_DC_EXTTAG       8
`define PRL_DC_MPS_LO       5
`define PRL_DC_RLXORD       4
`define PRL_DC_UR_EN        3
`define PRL_DC_FATAL_EN     2
`define PRL_DC_NONFATAL_EN  1
`define PRL_DC_CORR_EN      0
`define PRL_DC_WMASK        16'h01EF
// device status flags, bit 5 is pending
`define PRL_DS_UR           3
`define PRL_DS_FATAL        2
`define PRL_DS_NONFATAL     1
`define PRL_DS_CORR         0
`define PRL_DS_PEND         5
// payload size codes
`define PRL_MPS_128         3'h0
`define PRL_MPS_256         3'h1
// link capability defaults and fixed bits
`define PRL_LC_PORT_RST     8'h00
`define PRL_LC_FIXED        4'hE
`define PRL_LC_L1_RST       3'h2
`define PRL_LC_L0S_RST      3'h3
`define PRL_LC_ASPM_RST     2'h3
`define PRL_LC_WIDTH_RST    6'h04
`define PRL_LC_SPD_GEN1     4'h1
`define PRL_LC_SPD_GEN2     4'h2
`endif

// file: hdl/prl_pkg.sv
// Purpose: types shared by the port register bank
// Assumes: nothing
// Notes:   constants live in prl_params.svh
package prl_pkg;
  // one configuration access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } prl_cfg_req_t;
  // error events seen by the port, one-cycle pulses
  typedef struct packed {
    logic ur_np;       // inbound non-posted request unsupported
    logic ur_fwd_cpl;  // forwarded peer completion with UR status
    logic fatal;
    logic nonfatal;
    logic corr;
  } prl_err_evt_t;
  // error report events toward system error logic
  typedef struct packed {
    logic ur;
    logic fatal;
    logic nonfatal;
    logic corr;
  } prl_err_rpt_t;
  // link capability write-once content
  typedef struct packed {
    logic [7:0] port_num;
    logic [2:0] l1_lat;
    logic [2:0] l0s_lat;
    logic [1:0] aspm;
    logic [5:0] width;
    logic [3:0] speed;
  } prl_link_cap_t;
endpackage

// file: hdl/prl_regs.sv
// Purpose: device control/status and link capability registers of a port
// Assumes: single clock, config accesses and error events on i_clk
// Notes:   read data returns one cycle after the read strobe
//
// Overview of operation
// - control bit 8 is read-write and enables 8-bit requester tags.
// - payload code 001 means 256 bytes; everything else 128 bytes.
// - port limits own and accepted payloads to the programmed size.
// - relaxed ordering bit reads zero; never set on own requests.
// - control bit 3 enables reporting of detected unsupported requests.
// - control bit 2 enables reporting of link fatal errors.
// - control bit 1 enables reporting of link non-fatal errors.
// - control bit 0 enables reporting of link correctable errors.
// - enables gate only link errors, never internal unit errors.
// - transactions pending status bit always reads zero.
// - status bit 3 sets on inbound unsupported non-posted request.
// - forwarded peer UR completions never set status bit 3.
// - status bits 2..0 set regardless of enables; write one clears.
// - firmware writes port number once; port reports it.
// - capability bits 21..19 read one, clock PM bit reads zero.
// - L1 exit latency field is write-once, default 010.
// - L0s exit latency field is write-once, default 011.
// - ASPM support field is write-once, default 11.
// - maximum width field is write-once, default x4 code.
// - speed field is write-once; chipset port defaults to 0001.
// - chipset port link control bits 11..9 read zero.
// - max payload supported is 256 bytes, chipset port 128.
`include "prl_params.svh"
`timescale 1ns/1ns
`default_nettype none
module prl_regs
  import prl_pkg::*;
#(
  parameter bit IS_CHIPSET_PORT = 1'b0
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire prl_cfg_req_t i_cfg,
  input  wire prl_err_evt_t i_err_evt,
  input  wire logic         i_int_err,
  output logic [31:0]       o_cfg_rdata,
  output logic              o_cfg_rvalid,
  output logic              o_ext_tag_en,
  output logic              o_mps_256,
  output logic              o_relaxed_ord,
  output prl_err_rpt_t      o_err_rpt,
  output logic              o_int_err_rpt,
  output prl_link_cap_t     o_link_cap
);

  // speed default differs per port kind
  localparam logic [3:0] SPD_RST = IS_CHIPSET_PORT ?
    `PRL_LC_SPD_GEN1 : `PRL_LC_SPD_GEN2;

  // true when any byte lane of bits hi..lo is enabled
  function automatic logic lane_hit(input logic [3:0] be,
                                    input int lo,
                                    input int hi);
    logic hit;
    hit = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (be[b] && (b >= lo / 8) && (b <= hi / 8)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic [15:0]    devctl_reg;
  logic [3:0]     dev_status_reg;
  prl_link_cap_t  link_cap_reg;
  logic [5:0]     wo_lock_reg;
  logic           wr_dc;
  logic           wr_lc;
  logic [3:0]     sts_set;
  logic [3:0]     sts_clr;
  logic [5:0]     wo_hit;
  logic [31:0]    lc_word;

  // access decode
  assign wr_dc = i_cfg.wr && (i_cfg.addr == `PRL_OFS_DEVCTL);
  assign wr_lc = i_cfg.wr && (i_cfg.addr == `PRL_OFS_LINK_CAP);

  // hardware set terms; forwarded completions are not counted
  assign sts_set = {i_err_evt.ur_np,
                    i_err_evt.fatal,
                    i_err_evt.nonfatal,
                    i_err_evt.corr};
  // write-one clear from the upper half of the dword
  assign sts_clr = (wr_dc && i_cfg.be[2]) ?
                   i_cfg.wdata[19:16] : 4'h0;

  // byte lanes touched per write-once field
  assign wo_hit = {lane_hit(i_cfg.be, 24, 31),
                   lane_hit(i_cfg.be, 15, 17),
                   lane_hit(i_cfg.be, 12, 14),
                   lane_hit(i_cfg.be, 10, 11),
                   lane_hit(i_cfg.be, 4, 9),
                   lane_hit(i_cfg.be, 0, 3)};

  // device control: tag, payload and reporting enables
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      devctl_reg <= 16'h0000;
    end else if (wr_dc) begin
      for (int b = 0; b < 2; b++) begin
        if (i_cfg.be[b]) begin
          devctl_reg[b*8 +: 8] <= i_cfg.wdata[b*8 +: 8] &
            8'(`PRL_DC_WMASK >> (b*8));
        end
      end
    end
  end

  // device status flags, set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dev_status_reg <= 4'h0;
    end else begin
      dev_status_reg <= (dev_status_reg & ~sts_clr) | sts_set;
    end
  end

  // link capability write-once fields
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      link_cap_reg.port_num <= `PRL_LC_PORT_RST;
      link_cap_reg.l1_lat   <= `PRL_LC_L1_RST;
      link_cap_reg.l0s_lat  <= `PRL_LC_L0S_RST;
      link_cap_reg.aspm     <= `PRL_LC_ASPM_RST;
      link_cap_reg.width    <= `PRL_LC_WIDTH_RST;
      link_cap_reg.speed    <= SPD_RST;
      wo_lock_reg           <= 6'h00;
    end else if (wr_lc) begin
      if (wo_hit[5] && !wo_lock_reg[5]) begin
        link_cap_reg.port_num <= i_cfg.wdata[31:24];
      end
      if (wo_hit[4] && !wo_lock_reg[4]) begin
        link_cap_reg.l1_lat <= i_cfg.wdata[17:15];
      end
      if (wo_hit[3] && !wo_lock_reg[3]) begin
        link_cap_reg.l0s_lat <= i_cfg.wdata[14:12];
      end
      if (wo_hit[2] && !wo_lock_reg[2]) begin
        link_cap_reg.aspm <= i_cfg.wdata[11:10];
      end
      if (wo_hit[1] && !wo_lock_reg[1]) begin
        link_cap_reg.width <= i_cfg.wdata[9:4];
      end
      if (wo_hit[0] && !wo_lock_reg[0]) begin
        link_cap_reg.speed <= i_cfg.wdata[3:0];
      end
      wo_lock_reg <= wo_lock_reg | wo_hit;
    end
  end

  // assembled capability word with fixed bits
  assign lc_word = {link_cap_reg.port_num, 2'b00,
                    `PRL_LC_FIXED,
                    link_cap_reg.l1_lat, link_cap_reg.l0s_lat,
                    link_cap_reg.aspm, link_cap_reg.width,
                    link_cap_reg.speed};

  // read path, unmapped offsets return zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cfg_rdata  <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg.rd;
      if (i_cfg.rd) begin
        unique case (i_cfg.addr)
          `PRL_OFS_DEVCTL: o_cfg_rdata <= {12'h000, dev_status_reg,
                                           devctl_reg};
          `PRL_OFS_LINK_CAP: o_cfg_rdata <= lc_word;
          `PRL_OFS_LINK_CTL: o_cfg_rdata <= 32'h0000_0000;
          default:         o_cfg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // steering outputs toward the transaction logic
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ext_tag_en  <= 1'b0;
      o_mps_256     <= 1'b0;
      o_relaxed_ord <= 1'b0;
      o_link_cap    <= '0;
    end else begin
      o_ext_tag_en  <= devctl_reg[`PRL_DC_EXTTAG];
      o_mps_256     <= !IS_CHIPSET_PORT &&
        (devctl_reg[`PRL_DC_MPS_LO +: 3] == `PRL_MPS_256);
      o_relaxed_ord <= 1'b0;
      o_link_cap    <= link_cap_reg;
    end
  end

  // error report events, link errors gated by enables
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_err_rpt     <= '0;
      o_int_err_rpt <= 1'b0;
    end else begin
      o_err_rpt.ur       <= sts_set[3] &
                            devctl_reg[`PRL_DC_UR_EN];
      o_err_rpt.fatal    <= sts_set[2] &
                            devctl_reg[`PRL_DC_FATAL_EN];
      o_err_rpt.nonfatal <= sts_set[1] &
                            devctl_reg[`PRL_DC_NONFATAL_EN];
      o_err_rpt.corr     <= sts_set[0] &
                            devctl_reg[`PRL_DC_CORR_EN];
      o_int_err_rpt      <= i_int_err;
    end
  end

  // named steps used by the checks below
  sequence s_rd_dc;
    i_cfg.rd && (i_cfg.addr == `PRL_OFS_DEVCTL);
  endsequence
  sequence s_rd_lc;
    i_cfg.rd && (i_cfg.addr == `PRL_OFS_LINK_CAP);
  endsequence
  sequence s_rd_lk;
    i_cfg.rd && (i_cfg.addr == `PRL_OFS_LINK_CTL);
  endsequence
  // a port number write arriving after the field has locked
  sequence s_port_locked;
    wr_lc && wo_hit[5] && wo_lock_reg[5];
  endsequence

  AST_EXTTAG_OUT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    wr_dc && i_cfg.be[1] |=> ##1 o_ext_tag_en == $past(i_cfg.wdata[8], 2)
  ) else $error("ext tag enable not following write");

  AST_EXTTAG_RD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd_dc |=> o_cfg_rdata[8] == $past(devctl_reg[8])
  ) else $error("ext tag enable read back wrong");

  AST_MPS_ALIAS: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_mps_256 |-> !IS_CHIPSET_PORT &&
      $past(devctl_reg[7:5]) == `PRL_MPS_256
  ) else $error("payload size decoded wrongly");

  AST_RLX_ZERO: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd_dc |=> o_cfg_rvalid && !o_cfg_rdata[4] && !o_relaxed_ord
  ) else $error("relaxed ordering not zero");

  AST_PEND_ZERO: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd_dc |=> o_cfg_rdata[16 + `PRL_DS_PEND] == 1'b0
  ) else $error("transactions pending not zero");

  AST_UR_SET: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.ur_np |=> dev_status_reg[3]
  ) else $error("unsupported request flag not set");

  AST_FWD_NO_UR: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.ur_fwd_cpl && !i_err_evt.ur_np && !dev_status_reg[3]
      |=> !dev_status_reg[3]
  ) else $error("forwarded completion set UR flag");

  AST_FWD_NO_RPT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.ur_fwd_cpl && !i_err_evt.ur_np |=> !o_err_rpt.ur
  ) else $error("forwarded completion raised UR report");

  AST_SET_WINS: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.fatal && sts_clr[2] |=> dev_status_reg[2]
  ) else $error("clear beat a set in same cycle");

  AST_W1C: assert property (
    @(posedge i_clk) disable iff (i_reset)
    sts_clr[1] && !i_err_evt.nonfatal |=> !dev_status_reg[1]
  ) else $error("write one did not clear flag");

  AST_L1_RD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd_lc |=> o_cfg_rdata[17:15] == $past(link_cap_reg.l1_lat)
  ) else $error("exit latency field read back wrong");

  AST_SPD_RD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd_lc |=> o_cfg_rdata[3:0] == $past(link_cap_reg.speed)
  ) else $error("speed field read back wrong");

  AST_CAP_FIXED: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd_lc |=> o_cfg_rdata[21:18] == `PRL_LC_FIXED
  ) else $error("fixed capability bits wrong");

  AST_WO_ONCE: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_port_locked |=> $stable(link_cap_reg.port_num)
  ) else $error("write-once field took second write");

  AST_PORT_REPORT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    wr_lc && wo_hit[5] && !wo_lock_reg[5]
      |=> ##1 o_link_cap.port_num == $past(i_cfg.wdata[31:24], 2)
  ) else $error("port number not reported");

  AST_CHIPSET_PORT_LINK_CONTROL_ZERO: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd_lk |=> o_cfg_rdata[11:9] == 3'h0
  ) else $error("link control bits not zero");

  AST_REPORT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.fatal |=> o_err_rpt.fatal == $past(devctl_reg[2])
  ) else $error("fatal report not gated by enable");

  AST_UR_REPORT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.ur_np |=> o_err_rpt.ur == $past(devctl_reg[`PRL_DC_UR_EN])
  ) else $error("unsupported request report not gated");

  AST_NF_REPORT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.nonfatal |=>
      o_err_rpt.nonfatal == $past(devctl_reg[`PRL_DC_NONFATAL_EN])
  ) else $error("non-fatal report not gated by enable");

  AST_CORR_REPORT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_err_evt.corr |=> o_err_rpt.corr == $past(devctl_reg[`PRL_DC_CORR_EN])
  ) else $error("correctable report not gated by enable");

  AST_INT_UNGATED: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_int_err |=> o_int_err_rpt
  ) else $error("internal error report gated");

endmodule
`default_nettype wire
